// ===== verilog/pmp_pkg.sv
// shared constants, field layout and carrier types of the memory protection unit
// Overview of operation
// - Only the top_of_range_mode matching is offered, with at most sixteen regions.
// - The checking logic exists only for a region count above zero, which sets the region total.
// - A granularity parameter sets the smallest region, four bytes by default.
// - Region settings live in up to four configuration CSRs, indices zero to three, four regions each.
// - Each region has an address CSR, indices zero to fifteen, present only up to the region count.
// - Every fetch and data address is compared against all configured regions.
// - A matched store needs the write bit, a load the read bit and a fetch the execute bit.
// - A missing right raises the fetch, load or store access fault matching the access.
// - Checks apply by default only to user-mode accesses.
// - A locked region is also checked for machine-mode accesses.
// - Writes to a locked region's configuration and address CSRs are ignored until reset.
// - Regions are checked in parallel and the most restrictive rights of all matches apply.
// - Above the critical region count an extra register stage enters the memory interfaces.
// - With that stage every fetch and data access takes one more cycle.
package pmp_pkg;
    localparam int PMP_MAX_REGIONS = 16;
    localparam int PMP_CRIT_REGIONS = 8;
    localparam int PMP_GRAN_BYTES = 4;
    localparam int PMP_AW = 30;
    localparam int PMP_CFG_PER_CSR = 4;
    localparam int PMP_CFG_W = 8;
    localparam int PMP_CNT_W = 16;
    // apb byte addresses
    localparam logic [7:0] PMP_CFG_BASE = 8'h00;
    localparam logic [7:0] PMP_ADDR_BASE = 8'h10;
    localparam logic [7:0] PMP_STATUS_OFF = 8'h50;
    localparam int PMP_WORD_LSB = 2;
    // configuration byte layout
    localparam int PMP_BIT_R = 0;
    localparam int PMP_BIT_W = 1;
    localparam int PMP_BIT_X = 2;
    localparam int PMP_A_LSB = 3;
    localparam int PMP_A_MSB = 4;
    localparam int PMP_BIT_L = 7;
    localparam logic [1:0] PMP_A_OFF = 2'h0;
    localparam logic [1:0] PMP_A_TOR = 2'h1;
    localparam logic [7:0] PMP_CFG_RST = 8'h00;
    localparam logic [7:0] PMP_CFG_KEEP = 8'h9f;
    localparam logic [29:0] PMP_ADDR_RST = 30'h00000000;
    // status word layout
    localparam int PMP_ST_NUM_LSB = 16;
    localparam int PMP_ST_STAGE = 24;

    typedef struct packed {
        logic valid;
        logic user;
        logic [31:0] addr;
    } pmp_fetch_req_s;

    typedef struct packed {
        logic valid;
        logic user;
        logic write;
        logic [31:0] addr;
    } pmp_data_req_s;

    typedef struct packed {
        logic valid;
        logic fault;
    } pmp_fetch_rsp_s;

    typedef struct packed {
        logic valid;
        logic load_fault;
        logic store_fault;
    } pmp_data_rsp_s;
endpackage

// ===== verilog/pmp_check.sv
// parallel top-of-range comparison of one address against all regions
`timescale 1ns/1ps
module pmp_check
    import pmp_pkg::*;
#(
    parameter int NUM = PMP_MAX_REGIONS,
    parameter int GRAN = PMP_GRAN_BYTES
) (
    input wire logic [NUM*PMP_CFG_W-1:0] cfg_in,
    input wire logic [NUM*PMP_AW-1:0] top_in,
    input wire logic [PMP_AW-1:0] addr_in,
    input wire logic user_in,
    output logic r_ok_out,
    output logic w_ok_out,
    output logic x_ok_out
);
    localparam int GLSB = $clog2(GRAN) - PMP_WORD_LSB;
    localparam logic [PMP_AW-1:0] GMASK = ~((PMP_AW'(1) << GLSB) - PMP_AW'(1));

    generate
        if (NUM > 0) begin : g_on
            logic [NUM-1:0] deny_r;
            logic [NUM-1:0] deny_w;
            logic [NUM-1:0] deny_x;
            for (genvar i = 0; i < NUM; i++) begin : g_reg
                logic [PMP_CFG_W-1:0] c;
                logic [PMP_AW-1:0] hi;
                logic [PMP_AW-1:0] lo;
                logic hit;
                logic active;
                assign c = cfg_in[i*PMP_CFG_W +: PMP_CFG_W];
                assign hi = top_in[i*PMP_AW +: PMP_AW] & GMASK;
                if (i == 0) begin : g_lo0
                    assign lo = '0;
                end else begin : g_lon
                    assign lo = top_in[(i-1)*PMP_AW +: PMP_AW] & GMASK;
                end
                // only top_of_range_mode can ever match
                assign hit = (c[PMP_A_MSB:PMP_A_LSB] == PMP_A_TOR) &&
                    (addr_in >= lo) && (addr_in < hi);
                assign active = hit && (user_in || c[PMP_BIT_L]);
                assign deny_r[i] = active && !c[PMP_BIT_R];
                assign deny_w[i] = active && !c[PMP_BIT_W];
                assign deny_x[i] = active && !c[PMP_BIT_X];
            end
            // any denying match wins, no priority among regions
            assign r_ok_out = ~|deny_r;
            assign w_ok_out = ~|deny_w;
            assign x_ok_out = ~|deny_x;
        end else begin : g_off
            assign r_ok_out = 1'b1;
            assign w_ok_out = 1'b1;
            assign x_ok_out = 1'b1;
        end
    endgenerate
endmodule

// ===== verilog/pmp_pipe.sv
// response register with an optional second stage
`timescale 1ns/1ps
module pmp_pipe #(
    parameter int W = 5,
    parameter bit EXTRA = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1 <= '0;
        end else begin
            s1 <= d_in;
        end
    end

    generate
        if (EXTRA) begin : g_extra
            logic [W-1:0] s2;
            // second stage registers s1 again, adding one cycle of latency
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s2 <= '0;
                end else begin
                    s2 <= s1;
                end
            end
            assign q_out = s2;
        end else begin : g_single
            assign q_out = s1;
        end
    endgenerate
endmodule

// ===== verilog/pmp_top.sv
// memory protection unit top: csr file over apb, checks and response stage
`timescale 1ns/1ps
module pmp_top
    import pmp_pkg::*;
#(
    parameter int NUM_REGIONS = PMP_MAX_REGIONS,
    parameter int GRANULARITY = PMP_GRAN_BYTES
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire pmp_fetch_req_s if_req_in,
    input wire pmp_data_req_s d_req_in,
    output pmp_fetch_rsp_s if_rsp_out,
    output pmp_data_rsp_s d_rsp_out
);
    localparam int NUM = (NUM_REGIONS > PMP_MAX_REGIONS) ?
        PMP_MAX_REGIONS : NUM_REGIONS;
    localparam int NREG = (NUM > 0) ? NUM : 1;
    localparam int NCFG = (NUM + PMP_CFG_PER_CSR - 1) / PMP_CFG_PER_CSR;
    localparam bit EXTRA = (NUM > PMP_CRIT_REGIONS);
    localparam int RSP_LAT = EXTRA ? 2 : 1;
    localparam int RSP_W = $bits(pmp_fetch_rsp_s) + $bits(pmp_data_rsp_s);

    logic rst_s1;
    logic rst_n;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [PMP_CFG_W-1:0] cfg_q [NREG];
    logic [PMP_AW-1:0] addr_q [NREG];
    logic [NREG*PMP_CFG_W-1:0] cfg_flat;
    logic [NREG*PMP_AW-1:0] addr_flat;
    logic [PMP_CNT_W-1:0] fault_cnt;
    logic setup;
    logic apb_wr;
    logic sel_cfg;
    logic sel_addr;
    logic sel_stat;
    logic [4:0] idx;
    logic [31:0] rd_val;
    logic if_r;
    logic if_w;
    logic if_x;
    logic d_r;
    logic d_w;
    logic d_x;
    pmp_fetch_rsp_s next_if_rsp;
    pmp_data_rsp_s next_d_rsp;
    logic [RSP_W-1:0] rsp_q;
    logic [NREG-1:0] locks;

    // reset is released through two flops
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // illegal matching modes fall back to off, reserved bits read zero
    function automatic logic [PMP_CFG_W-1:0] legal_cfg(
        input logic [PMP_CFG_W-1:0] v);
        logic [PMP_CFG_W-1:0] r;
        r = v & PMP_CFG_KEEP;
        if (v[PMP_A_MSB:PMP_A_LSB] != PMP_A_TOR) begin
            r[PMP_A_MSB:PMP_A_LSB] = PMP_A_OFF;
        end
        return r;
    endfunction

    assign setup = psel_in && !penable_in;
    assign apb_wr = psel_in && penable_in && pready && pwrite_in;

    // decode: cfg words, then address words, then status
    always_comb begin
        sel_cfg = 1'b0;
        sel_addr = 1'b0;
        sel_stat = 1'b0;
        idx = paddr_in[6:2];
        if (paddr_in[1:0] != 2'h0) begin
            sel_cfg = 1'b0;
        end else if (paddr_in < PMP_ADDR_BASE) begin
            sel_cfg = (int'(paddr_in[3:2]) < NCFG);
            idx = {3'h0, paddr_in[3:2]};
        end else if (paddr_in < PMP_STATUS_OFF) begin
            idx = 5'((paddr_in - PMP_ADDR_BASE) >> PMP_WORD_LSB);
            sel_addr = (int'(idx) < NUM);
        end else if (paddr_in == PMP_STATUS_OFF) begin
            sel_stat = 1'b1;
        end
    end

    always_comb begin
        rd_val = 32'h00000000;
        for (int i = 0; i < NUM; i++) begin
            if (sel_cfg && (i / PMP_CFG_PER_CSR) == int'(idx)) begin
                rd_val[(i % PMP_CFG_PER_CSR)*PMP_CFG_W +: PMP_CFG_W] =
                    cfg_q[i];
            end
            if (sel_addr && i == int'(idx)) begin
                rd_val[PMP_AW-1:0] = addr_q[i];
            end
        end
        if (sel_stat) begin
            rd_val[PMP_CNT_W-1:0] = fault_cnt;
            rd_val[PMP_ST_NUM_LSB +: 5] = 5'(NUM);
            rd_val[PMP_ST_STAGE] = EXTRA;
        end
    end

    // one wait-free access phase: pready rises the edge after setup
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
            prdata <= pwrite_in ? 32'h00000000 : rd_val;
            pslverr <= !(sel_cfg || sel_addr || sel_stat);
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    assign prdata_out = prdata;
    assign pready_out = pready;
    assign pslverr_out = pslverr;

    generate
        for (genvar i = 0; i < NREG; i++) begin : g_csr
            localparam int CI = i / PMP_CFG_PER_CSR;
            localparam int LN = i % PMP_CFG_PER_CSR;
            logic addr_lock;
            if (i + 1 < NUM) begin : g_nl
                // a locked tor region above also freezes this bound
                assign addr_lock = cfg_q[i][PMP_BIT_L] ||
                    (cfg_q[i+1][PMP_BIT_L] &&
                    cfg_q[i+1][PMP_A_MSB:PMP_A_LSB] == PMP_A_TOR);
            end else begin : g_last
                assign addr_lock = cfg_q[i][PMP_BIT_L];
            end
            assign locks[i] = cfg_q[i][PMP_BIT_L] && (NUM > 0);
            always_ff @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_q[i] <= PMP_CFG_RST;
                end else if (apb_wr && sel_cfg && int'(idx) == CI &&
                    pstrb_in[LN] && !cfg_q[i][PMP_BIT_L]) begin
                    cfg_q[i] <= legal_cfg(pwdata_in[LN*PMP_CFG_W +:
                        PMP_CFG_W]);
                end
            end
            always_ff @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    addr_q[i] <= PMP_ADDR_RST;
                end else if (apb_wr && sel_addr && int'(idx) == i &&
                    (&pstrb_in) && !addr_lock) begin
                    addr_q[i] <= pwdata_in[PMP_AW-1:0];
                end
            end
            assign cfg_flat[i*PMP_CFG_W +: PMP_CFG_W] = cfg_q[i];
            assign addr_flat[i*PMP_AW +: PMP_AW] = addr_q[i];
            // checked per region so any locked region is watched
            property p_lock_hold;
                @(posedge mclk_in) disable iff (!rst_n)
                cfg_q[i][PMP_BIT_L] |=>
                    $stable(cfg_q[i]) && $stable(addr_q[i]);
            endproperty
            a_lock_hold: assert property (p_lock_hold)
                else $error("locked region changed");
        end
    endgenerate

    pmp_check #(
        .NUM(NUM),
        .GRAN(GRANULARITY)
    ) u_fetch_chk (
        .cfg_in(cfg_flat[NREG*PMP_CFG_W-1:0]),
        .top_in(addr_flat[NREG*PMP_AW-1:0]),
        .addr_in(if_req_in.addr[31:PMP_WORD_LSB]),
        .user_in(if_req_in.user),
        .r_ok_out(if_r),
        .w_ok_out(if_w),
        .x_ok_out(if_x)
    );

    pmp_check #(
        .NUM(NUM),
        .GRAN(GRANULARITY)
    ) u_data_chk (
        .cfg_in(cfg_flat[NREG*PMP_CFG_W-1:0]),
        .top_in(addr_flat[NREG*PMP_AW-1:0]),
        .addr_in(d_req_in.addr[31:PMP_WORD_LSB]),
        .user_in(d_req_in.user),
        .r_ok_out(d_r),
        .w_ok_out(d_w),
        .x_ok_out(d_x)
    );

    always_comb begin
        next_if_rsp.valid = if_req_in.valid;
        next_if_rsp.fault = if_req_in.valid && !if_x;
        next_d_rsp.valid = d_req_in.valid;
        next_d_rsp.load_fault = d_req_in.valid && !d_req_in.write &&
            !d_r;
        next_d_rsp.store_fault = d_req_in.valid && d_req_in.write &&
            !d_w;
    end

    pmp_pipe #(
        .W(RSP_W),
        .EXTRA(EXTRA)
    ) u_pipe (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .d_in({next_if_rsp, next_d_rsp}),
        .q_out(rsp_q)
    );

    assign {if_rsp_out, d_rsp_out} = rsp_q;

    // counts delivered faults; wraps silently
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            fault_cnt <= '0;
        end else begin
            fault_cnt <= fault_cnt + PMP_CNT_W'(if_rsp_out.fault) +
                PMP_CNT_W'(d_rsp_out.load_fault | d_rsp_out.store_fault);
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        psel_in && !penable_in;
    endsequence

    sequence s_done;
        pready_out ##1 !pready_out;
    endsequence

    property p_apb_answer;
        s_setup |=> s_done;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one cycle after setup");

    property p_fetch_lat;
        if_req_in.valid |-> ##[RSP_LAT:RSP_LAT] if_rsp_out.valid;
    endproperty
    a_fetch_lat: assert property (p_fetch_lat)
        else $error("fetch response latency wrong");

    property p_data_lat;
        !d_req_in.valid |-> ##[RSP_LAT:RSP_LAT] !d_rsp_out.valid;
    endproperty
    a_data_lat: assert property (p_data_lat)
        else $error("data response without request");

    property p_store_fault;
        d_req_in.valid && d_req_in.write && !d_w |->
            ##[RSP_LAT:RSP_LAT] d_rsp_out.store_fault;
    endproperty
    a_store_fault: assert property (p_store_fault)
        else $error("store without write right not faulted");

    property p_load_fault;
        d_req_in.valid && !d_req_in.write |->
            ##[RSP_LAT:RSP_LAT] (d_rsp_out.load_fault == !$past(d_r, RSP_LAT)
            && !d_rsp_out.store_fault);
    endproperty
    a_load_fault: assert property (p_load_fault)
        else $error("load fault does not follow read right");

    property p_fetch_fault;
        if_req_in.valid && !if_x |-> ##[RSP_LAT:RSP_LAT] if_rsp_out.fault;
    endproperty
    a_fetch_fault: assert property (p_fetch_fault)
        else $error("fetch without execute right not faulted");

    property p_machine_free;
        if_req_in.valid && !if_req_in.user && locks == '0 |->
            ##[RSP_LAT:RSP_LAT] !if_rsp_out.fault;
    endproperty
    a_machine_free: assert property (p_machine_free)
        else $error("unlocked machine fetch faulted");

    property p_fault_count;
        if_rsp_out.fault && !(d_rsp_out.load_fault || d_rsp_out.store_fault)
            |=> fault_cnt == $past(fault_cnt) + PMP_CNT_W'(1);
    endproperty
    a_fault_count: assert property (p_fault_count)
        else $error("fault counter did not step");
endmodule

// ===== dv/pmp_cpu_model.sv
// cpu-side model: turns bench commands into fetch and data requests
`timescale 1ns/1ps
module pmp_cpu_model
    import pmp_pkg::*;
(
    input wire logic clk_in,
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_kind_in,
    input wire logic cmd_user_in,
    input wire logic [31:0] cmd_addr_in,
    output pmp_fetch_req_s if_req_out,
    output pmp_data_req_s d_req_out
);
    // idle address toggles so a stale address never looks like a request
    logic [31:0] junk = 32'h0;

    initial begin
        if_req_out = '0;
        d_req_out = '0;
    end

    always @(posedge clk_in) begin
        junk <= ~junk;
        if_req_out.valid <= cmd_valid_in && cmd_kind_in == 2'h0;
        d_req_out.valid <= cmd_valid_in && cmd_kind_in != 2'h0;
        if_req_out.user <= cmd_user_in;
        d_req_out.user <= cmd_user_in;
        d_req_out.write <= cmd_kind_in == 2'h2;
        if_req_out.addr <= cmd_valid_in ? cmd_addr_in : junk;
        d_req_out.addr <= cmd_valid_in ? cmd_addr_in : ~junk;
    end
endmodule

// ===== dv/tb_pmp_top.sv
// self-checking bench for the memory protection unit
`timescale 1ns/1ps
module tb_pmp_top
    import pmp_pkg::*;
;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pmp_fetch_req_s if_req;
    pmp_data_req_s d_req;
    pmp_fetch_rsp_s if_rsp, if_rsp8;
    pmp_data_rsp_s d_rsp;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_kind = 2'h0;
    logic cmd_user = 1'b0;
    logic [31:0] cmd_addr = 32'h0;
    logic [33:0] aq[$];
    logic fq[$];
    logic [1:0] dq[$];
    logic [33:0] ae;
    logic [1:0] l1 = 2'h0, l2 = 2'h0;
    logic ready = 1'b0;
    logic [7:0] s_cfg[16];
    logic [29:0] s_top[16];
    int mismatches = 0, check_count = 0, fault_cnt = 0, seed, i, k, u;

    always #20 mclk_in = ~mclk_in;

    pmp_cpu_model cpu_u (.clk_in(mclk_in), .cmd_valid_in(cmd_valid),
        .cmd_kind_in(cmd_kind), .cmd_user_in(cmd_user),
        .cmd_addr_in(cmd_addr), .if_req_out(if_req), .d_req_out(d_req));

    pmp_top dut_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .if_req_in(if_req), .d_req_in(d_req), .if_rsp_out(if_rsp),
        .d_rsp_out(d_rsp));

    // at the critical count itself no extra stage may appear
    pmp_top #(.NUM_REGIONS(8)) dut_u8 (.mclk_in(mclk_in),
        .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(), .pready_out(), .pslverr_out(),
        .if_req_in(if_req), .d_req_in(d_req), .if_rsp_out(if_rsp8),
        .d_rsp_out());

    task automatic tally_and_finish();
        if (fq.size() + dq.size() + aq.size() != 0)
            mismatches++;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value apb %h expected %h seen %h", paddr, e, g);
        end
    endtask

    task automatic chk_rsp(input string w, input logic [1:0] e,
                           input logic [1:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", w, e, g);
        end
    endtask

    task automatic chk_lat(input string w, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", w, e, g);
        end
    endtask

    // one transfer; expectation is queued for the monitor
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] st,
                       input logic err, input logic [31:0] exp);
        int n;
        aq.push_back({~wr, err, exp});
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge mclk_in);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge mclk_in);
            if (pready === 1'b1)
                break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    function automatic logic ref_fault(input logic [1:0] kd, input logic us,
                                       input logic [31:0] a);
        logic f;
        logic [29:0] lo;
        logic [7:0] c;
        f = 1'b0;
        for (int r = 0; r < 16; r++) begin
            lo = (r == 0) ? 30'h0 : s_top[r-1];
            c = s_cfg[r];
            if (c[4:3] == 2'h1 && a[31:2] >= lo && a[31:2] < s_top[r] &&
                (us || c[7]) && !c[kd == 2'h0 ? 2 : (kd == 2'h1 ? 0 : 1)])
                f = 1'b1;
        end
        return f;
    endfunction

    // issues one request per cycle while called back to back
    task automatic access(input logic [1:0] kd, input logic us,
                          input logic [31:0] a);
        logic f;
        f = ref_fault(kd, us, a);
        if (kd == 2'h0)
            fq.push_back(f);
        else
            dq.push_back(kd == 2'h1 ? {f, 1'b0} : {1'b0, f});
        fault_cnt += f;
        cmd_valid <= 1'b1;
        cmd_kind <= kd;
        cmd_user <= us;
        cmd_addr <= a;
        @(posedge mclk_in);
    endtask

    always @(negedge mclk_in) begin
        if (ready) begin
            chk_lat("fetch valid", l2[1], if_rsp.valid);
            chk_lat("data valid", l2[0], d_rsp.valid);
            chk_lat("short fetch valid", l1[1], if_rsp8.valid);
            if (if_rsp.valid === 1'b1 && fq.size() > 0)
                chk_rsp("fetch fault", {1'b0, fq.pop_front()},
                        {1'b0, if_rsp.fault});
            if (d_rsp.valid === 1'b1 && dq.size() > 0)
                chk_rsp("data fault", dq.pop_front(),
                        {d_rsp.load_fault, d_rsp.store_fault});
            if (pready === 1'b1 && aq.size() > 0) begin
                ae = aq.pop_front();
                chk_reg(ae[32:0], {pslverr, ae[33] ? prdata : 32'h0});
            end
        end
        l2 = l1;
        l1 = {if_req.valid, d_req.valid};
    end

    task automatic do_reset();
        ready = 1'b0;
        arst_n_in <= 1'b0;
        repeat (20) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        ready = 1'b1;
    endtask

    initial begin
        seed = 32'h8b74;
        for (i = 0; i < 16; i++) begin
            s_cfg[i] = 8'h00;
            s_top[i] = 30'h0;
        end
        do_reset();
        apb(0, 8'h0c, 32'h0, 4'hf, 0, 32'h0);
        apb(0, 8'h4c, 32'h0, 4'hf, 0, 32'h0);
        apb(0, 8'h50, 32'h0, 4'hf, 0, 32'h0110_0000);
        apb(0, 8'h54, 32'h0, 4'hf, 1, 32'h0);
        apb(1, 8'h02, 32'h1, 4'hf, 1, 32'h0);
        // regions 1 and 3 cover the same words to test overlap
        s_top[0] = 30'h100;
        s_top[1] = 30'h200;
        s_top[2] = 30'h100;
        s_top[3] = 30'h200;
        s_top[4] = 30'h300;
        for (i = 0; i < 5; i++)
            apb(1, 8'h10 + 8'(4 * i), 32'(s_top[i]), 4'hf, 0, 32'h0);
        s_cfg[0] = 8'h09;
        s_cfg[1] = 8'h0f;
        s_cfg[3] = 8'h0a;
        s_cfg[4] = 8'h8c;
        apb(1, 8'h00, 32'h0a00_0f09, 4'hf, 0, 32'h0);
        // before any lock: machine fetch passes, user fetch faults
        access(2'h0, 1'b0, 32'h0);
        access(2'h0, 1'b1, 32'h0);
        cmd_valid <= 1'b0;
        apb(1, 8'h04, 32'h0000_008c, 4'hf, 0, 32'h0);
        apb(0, 8'h00, 32'h0, 4'hf, 0, 32'h0a00_0f09);
        apb(1, 8'h04, 32'h0000_070f, 4'hf, 0, 32'h0);
        apb(0, 8'h04, 32'h0, 4'hf, 0, 32'h0000_078c);
        apb(1, 8'h20, 32'h3ff, 4'hf, 0, 32'h0);
        apb(0, 8'h20, 32'h0, 4'hf, 0, 32'h300);
        apb(1, 8'h1c, 32'h3ff, 4'hf, 0, 32'h0);
        apb(0, 8'h1c, 32'h0, 4'hf, 0, 32'h200);
        apb(1, 8'h08, 32'h7f7f_7f7f, 4'hf, 0, 32'h0);
        apb(0, 8'h08, 32'h0, 4'hf, 0, 32'h0707_0707);
        apb(1, 8'h24, 32'hffff_ffff, 4'hf, 0, 32'h0);
        apb(0, 8'h24, 32'h0, 4'hf, 0, 32'h3fff_ffff);
        apb(1, 8'h28, 32'h5, 4'h3, 0, 32'h0);
        apb(0, 8'h28, 32'h0, 4'hf, 0, 32'h0);
        apb(1, 8'h0c, 32'hffff_05ff, 4'h2, 0, 32'h0);
        apb(0, 8'h0c, 32'h0, 4'hf, 0, 32'h0000_0500);
        for (i = 5; i < 16; i++)
            s_cfg[i] = (i == 13) ? 8'h05 : (i >= 8 && i < 12 ? 8'h07 : 8'h00);
        s_top[5] = 30'h3fff_ffff;
        // region edges, every kind, both modes, back to back
        foreach (s_top[j]) begin
            if (j < 5)
                for (k = 0; k < 3; k++)
                    for (u = 0; u < 2; u++) begin
                        access(2'(k), u[0], {s_top[j], 2'h0} - 32'h4);
                        access(2'(k), u[0], {s_top[j], 2'h0});
                    end
        end
        repeat (200)
            access(2'($unsigned($random(seed)) % 3), $random(seed),
                   $random(seed) & 32'h0000_1fff);
        cmd_valid <= 1'b0;
        repeat (4) @(posedge mclk_in);
        apb(0, 8'h50, 32'h0, 4'hf, 0, 32'h0110_0000 | 32'(fault_cnt));
        do_reset();
        apb(0, 8'h04, 32'h0, 4'hf, 0, 32'h0);
        apb(1, 8'h04, 32'h0000_000f, 4'hf, 0, 32'h0);
        apb(0, 8'h04, 32'h0, 4'hf, 0, 32'h0000_000f);
        repeat (3) @(posedge mclk_in);
        tally_and_finish();
    end
endmodule
